/* File: hdl/digital_video_out_port.v */
// Digital video output port with shared side-band pins
// Contract
// R1: Shared pixel clock pin can be chosen as dot clock PLL reference.
// R2: Shared pixel clock pin can instead be an interrupt for either port.
// R3: Field mode aligns overlay field with encoder field for interleaved use.
// R4: Active stall input stalls the pixel pipeline for one horizontal line.
// R5: Field/stall input has programmable polarity and an ignore setting.
// R6: Drive differential forwarded clock up to 165 MHz, true phase primary.
// R7: Put 12 bits on each forwarded clock edge, 24 bits per period.
// R8: Horizontal and vertical syncs each have their own polarity.
// R9: Blank mode: blank output marks active pixels without border.
// R10: Border mode: blank output marks active pixels plus border.
// R11: Active-low interrupt pin routable to either port; partner drives it.
// R12: All two-wire pins float while hard reset is held.
// R13: Provide control bus pair and two display data channel pairs.
// R14: Card straps eight-bit identity; device captures it for software.
// R15: Card-detect strap high means graphics bus, low means video mode.
// R16: In video mode the captured identity is readable at 71408h.
// R17: Low half of each pixel on first edge, high half on second.
`timescale 1ns/1ps
`default_nettype none
`include "dvo_port_defs.vh"
module digital_video_out_port (
	// Clock, reset, enable
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_clk_en,
	// Pixel stream in
	input wire [23:0] i_pix_data,
	input wire i_pix_valid,
	output wire o_pix_ready,
	// Timing configuration
	input wire [11:0] i_h_active,
	input wire [11:0] i_h_border,
	input wire [11:0] i_h_sync_start,
	input wire [11:0] i_h_sync_width,
	input wire [11:0] i_h_total,
	input wire [11:0] i_v_active,
	input wire [11:0] i_v_border,
	input wire [11:0] i_v_sync_start,
	input wire [11:0] i_v_sync_width,
	input wire [11:0] i_v_total,
	input wire i_hsync_pol,
	input wire i_vsync_pol,
	input wire i_blank_border_mode,
	// Video port pins
	output reg o_port_c_fwd_clock,
	output reg o_port_c_fwd_clock_n,
	output reg [11:0] o_port_c_pixel_bus,
	output reg o_port_c_hsync_out,
	output reg o_port_c_vsync_out,
	output reg o_port_c_blank_n,
	// Field/stall inputs and configuration
	input wire i_port_b_field_stall_in,
	input wire i_port_c_field_stall_in,
	input wire [1:0] i_fs_b_mode,
	input wire i_fs_b_pol,
	input wire [1:0] i_fs_c_mode,
	input wire i_fs_c_pol,
	input wire i_overlay_interleaved,
	// Field/stall results
	output reg o_port_b_field,
	output reg o_port_b_field_sync,
	output reg o_port_b_stall,
	output reg o_port_c_field,
	output reg o_port_c_field_sync,
	output wire o_port_c_stalled,
	// Shared clock/interrupt pins
	input wire i_shared_pixclk_or_irq_in,
	input wire [1:0] i_pixclk_mode,
	input wire i_shared_video_irq_n,
	input wire i_irq_route,
	output reg o_dot_clock_pll_ref_sel,
	output reg o_port_b_irq,
	output reg o_port_c_irq,
	// Two-wire pins
	input wire i_mux_ctrl_bus_scl,
	output wire o_mux_ctrl_bus_scl,
	output wire o_mux_ctrl_bus_scl_oe_n,
	input wire i_mux_ctrl_bus_sda,
	output wire o_mux_ctrl_bus_sda,
	output wire o_mux_ctrl_bus_sda_oe_n,
	input wire i_primary_ddc_scl,
	output wire o_primary_ddc_scl,
	output wire o_primary_ddc_scl_oe_n,
	input wire i_primary_ddc_sda,
	output wire o_primary_ddc_sda,
	output wire o_primary_ddc_sda_oe_n,
	input wire i_secondary_ddc_scl,
	output wire o_secondary_ddc_scl,
	output wire o_secondary_ddc_scl_oe_n,
	input wire i_secondary_ddc_sda,
	output wire o_secondary_ddc_sda,
	output wire o_secondary_ddc_sda_oe_n,
	// Two-wire core side
	input wire [5:0] i_twowire_drive_low,
	output wire [5:0] o_twowire_level,
	// Straps and identity
	input wire [7:0] i_card_ident_strap,
	input wire i_card_detect,
	output reg o_dvo_mode,
	output reg [7:0] o_card_ident_reg,
	output reg o_ident_valid
);
	// ***************************************
	// Functions
	// ***************************************

	// True while cnt lies in [start, start+len)
	function in_window;
		input [11:0] cnt;
		input [11:0] start;
		input [11:0] len;
		reg [12:0] end_pos;
		begin
			end_pos = {1'b0, start} + {1'b0, len};
			in_window = ({1'b0, cnt} >= {1'b0, start}) &&
				({1'b0, cnt} < end_pos);
		end
	endfunction

	// True on the last count of a period of the given total
	function at_last;
		input [11:0] cnt;
		input [11:0] total;
		begin
			at_last = (cnt == (total - 12'h001));
		end
	endfunction

	// ***************************************
	// Pin synchronisers
	// ***************************************
	reg [16:0] sync1;
	reg [16:0] sync2;
	wire [16:0] pins;

	assign pins = {i_card_ident_strap, i_card_detect,
		i_shared_pixclk_or_irq_in, i_shared_video_irq_n,
		i_secondary_ddc_sda, i_secondary_ddc_scl,
		i_primary_ddc_sda, i_primary_ddc_scl,
		i_mux_ctrl_bus_sda, i_mux_ctrl_bus_scl};

	// Two stages; only the second stage is read by logic
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			sync1 <= `SYNC_RST;
			sync2 <= `SYNC_RST;
		end else if (i_clk_en) begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	// ***************************************
	// Two-wire pins
	// ***************************************
	reg [5:0] tw_oe_n;

	// Open drain: output level is always low, enable decides
	assign o_mux_ctrl_bus_scl = 1'b0; // R13
	assign o_mux_ctrl_bus_sda = 1'b0;
	assign o_primary_ddc_scl = 1'b0;
	assign o_primary_ddc_sda = 1'b0;
	assign o_secondary_ddc_scl = 1'b0;
	assign o_secondary_ddc_sda = 1'b0;
	assign o_mux_ctrl_bus_scl_oe_n = tw_oe_n[0];
	assign o_mux_ctrl_bus_sda_oe_n = tw_oe_n[1];
	assign o_primary_ddc_scl_oe_n = tw_oe_n[2];
	assign o_primary_ddc_sda_oe_n = tw_oe_n[3];
	assign o_secondary_ddc_scl_oe_n = tw_oe_n[4];
	assign o_secondary_ddc_sda_oe_n = tw_oe_n[5];
	assign o_twowire_level = sync2[5:0];

	// Reset beats the enable so the pins float at once
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			tw_oe_n <= 6'h3f; // R12
		end else if (i_clk_en) begin
			tw_oe_n <= ~i_twowire_drive_low; // R13
		end
	end

	// ***************************************
	// Shared clock and interrupt pins
	// ***************************************
	wire pixclk_s;
	wire irq_s;

	assign pixclk_s = sync2[`SYNC_PIXCLK];
	assign irq_s = !sync2[`SYNC_IRQ_N];

	// Role of the shared clock pin and interrupt routing
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			o_dot_clock_pll_ref_sel <= 1'b0;
			o_port_b_irq <= 1'b0;
			o_port_c_irq <= 1'b0;
		end else if (i_clk_en) begin
			o_dot_clock_pll_ref_sel <=
				(i_pixclk_mode == `PIXCLK_ROLE_REF); // R1
			o_port_b_irq <=
				((i_pixclk_mode == `PIXCLK_ROLE_IRQ_B) && pixclk_s) ||
				((i_irq_route == `IRQ_ROUTE_B) && irq_s); // R2 R11
			o_port_c_irq <=
				((i_pixclk_mode == `PIXCLK_ROLE_IRQ_C) && pixclk_s) ||
				((i_irq_route == `IRQ_ROUTE_C) && irq_s); // R2 R11
		end
	end

	// ***************************************
	// Straps
	// ***************************************
	reg [1:0] cap_cnt;

	// Straps are caught once, after the synchroniser has filled
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			cap_cnt <= 2'h0;
			o_dvo_mode <= 1'b0;
			o_card_ident_reg <= 8'h00;
			o_ident_valid <= 1'b0;
		end else if (i_clk_en && !o_ident_valid) begin
			cap_cnt <= cap_cnt + 2'h1;
			if (cap_cnt == `STRAP_CAPTURE_CNT) begin
				o_ident_valid <= 1'b1; // R14
				o_dvo_mode <= !sync2[`SYNC_DETECT]; // R15
				o_card_ident_reg <= sync2[`SYNC_DETECT] ? 8'h00 :
					sync2[16:9]; // R16
			end
		end
	end

	// ***************************************
	// Field and stall inputs
	// ***************************************
	wire b_field;
	wire b_edge;
	wire b_stall;
	wire c_field;
	wire c_edge;
	wire c_stall;

	field_stall_cond u_fs_b (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_port_b_field_stall_in),
		.i_mode(i_fs_b_mode),
		.i_pol(i_fs_b_pol),
		.o_field(b_field),
		.o_field_edge(b_edge),
		.o_stall_req(b_stall)
	);

	field_stall_cond u_fs_c (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_port_c_field_stall_in),
		.i_mode(i_fs_c_mode),
		.i_pol(i_fs_c_pol),
		.o_field(c_field),
		.o_field_edge(c_edge),
		.o_stall_req(c_stall)
	);

	// Overlay field follows the encoder only for interleaved sources
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			o_port_b_field <= 1'b0;
			o_port_b_field_sync <= 1'b0;
			o_port_b_stall <= 1'b0;
			o_port_c_field <= 1'b0;
			o_port_c_field_sync <= 1'b0;
		end else if (i_clk_en) begin
			o_port_b_field <= b_field && i_overlay_interleaved; // R3
			o_port_b_field_sync <= b_edge && i_overlay_interleaved;
			o_port_b_stall <= b_stall; // R4
			o_port_c_field <= c_field && i_overlay_interleaved; // R3
			o_port_c_field_sync <= c_edge && i_overlay_interleaved;
		end
	end

	// ***************************************
	// Pixel FIFO
	// ***************************************
	wire [23:0] fifo_data;
	wire fifo_valid;
	wire fifo_pop;

	pixel_fifo #(
		.WIDTH(`PIX_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_data(i_pix_data),
		.i_valid(i_pix_valid),
		.o_ready(o_pix_ready),
		.o_data(fifo_data),
		.o_valid(fifo_valid),
		.i_ready(fifo_pop)
	);

	// ***************************************
	// Timing and output pipeline
	// ***************************************
	reg phase;
	reg [11:0] hcnt;
	reg [11:0] vcnt;
	reg [12:0] stall_cnt;
	reg [11:0] upper_hold;
	wire stalled;
	wire active;
	wire bordered;
	wire mark;

	assign stalled = (stall_cnt != 13'h0000);
	assign o_port_c_stalled = stalled;
	assign active = (hcnt < i_h_active) && (vcnt < i_v_active);
	assign bordered = in_window(hcnt, 12'h000, i_h_active + i_h_border) &&
		in_window(vcnt, 12'h000, i_v_active + i_v_border);
	assign mark = i_blank_border_mode ? bordered : active; // R9 R10
	// Pixels are taken only at a period start; an empty FIFO shows black
	assign fifo_pop = !phase && active && !stalled;

	// Line stall counted in system cycles, so its length ignores phase
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			stall_cnt <= 13'h0000;
		end else if (i_clk_en) begin
			if (c_stall && !stalled) begin
				stall_cnt <= {i_h_total, 1'b0}; // R4
			end else if (stalled) begin
				stall_cnt <= stall_cnt - 13'h0001;
			end
		end
	end

	// Raster counters advance at the end of each unstalled pixel period
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			hcnt <= 12'h000;
			vcnt <= 12'h000;
		end else if (i_clk_en && phase && !stalled) begin
			if (at_last(hcnt, i_h_total)) begin
				hcnt <= 12'h000;
				vcnt <= at_last(vcnt, i_v_total) ? 12'h000 :
					vcnt + 12'h001;
			end else begin
				hcnt <= hcnt + 12'h001;
			end
		end
	end

	// Clock is system clock over two, so 100 MHz stays under the limit
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			phase <= 1'b0;
			o_port_c_fwd_clock <= 1'b0;
			o_port_c_fwd_clock_n <= 1'b1;
			o_port_c_pixel_bus <= 12'h000;
			upper_hold <= 12'h000;
			o_port_c_hsync_out <= 1'b0;
			o_port_c_vsync_out <= 1'b0;
			o_port_c_blank_n <= 1'b0;
		end else if (i_clk_en) begin
			phase <= !phase;
			o_port_c_fwd_clock <= !phase; // R6
			o_port_c_fwd_clock_n <= phase; // R6
			if (!phase) begin
				// First edge carries the low half
				if (fifo_pop && fifo_valid) begin
					o_port_c_pixel_bus <= fifo_data[11:0]; // R7 R17
					upper_hold <= fifo_data[23:12]; // R17
				end else begin
					o_port_c_pixel_bus <= 12'h000;
					upper_hold <= 12'h000;
				end
				o_port_c_hsync_out <= in_window(hcnt, i_h_sync_start,
					i_h_sync_width) ^ i_hsync_pol; // R8
				o_port_c_vsync_out <= in_window(vcnt, i_v_sync_start,
					i_v_sync_width) ^ i_vsync_pol; // R8
				o_port_c_blank_n <= mark && !stalled; // R9 R10
			end else begin
				o_port_c_pixel_bus <= upper_hold; // R7 R17
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/field_stall_cond.v */
// Field/stall input conditioner: sync, polarity, mode decode
`timescale 1ns/1ps
`default_nettype none
`include "dvo_port_defs.vh"
module field_stall_cond (
	// Clock and control
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_clk_en,
	// Pin and configuration
	input wire i_pin,
	input wire [1:0] i_mode,
	input wire i_pol,
	// Decoded results
	output reg o_field,
	output reg o_field_edge,
	output reg o_stall_req
);
	reg sync1;
	reg sync2;
	reg sync3;
	wire act;
	wire act_prev;

	// High polarity bit means the input is active low
	assign act = sync2 ^ i_pol; // R5
	assign act_prev = sync3 ^ i_pol;

	// Pin synchroniser, then one more stage for edge finding
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else if (i_clk_en) begin
			sync1 <= i_pin;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Mode decode; the off setting ignores the pin entirely
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			o_field <= 1'b0;
			o_field_edge <= 1'b0;
			o_stall_req <= 1'b0;
		end else if (i_clk_en) begin
			o_field <= (i_mode == `FS_MODE_FIELD) && act; // R5
			o_field_edge <= (i_mode == `FS_MODE_FIELD) && (sync2 != sync3);
			o_stall_req <= (i_mode == `FS_MODE_STALL) && act && !act_prev; // R4
		end
	end
endmodule
`default_nettype wire

/* File: hdl/pixel_fifo.v */
// Pixel word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and control
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_clk_en,
	// Fill side
	input wire [WIDTH-1:0] i_data,
	input wire i_valid,
	output wire o_ready,
	// Drain side
	output wire [WIDTH-1:0] o_data,
	output wire o_valid,
	input wire i_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// Full and empty come from the count, never from pointer guesses
	assign o_ready = (count != DEPTH[AW:0]) && i_clk_en;
	assign o_valid = (count != {(AW+1){1'b0}});
	assign o_data = mem[rd_ptr];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready && i_clk_en;

	// Storage array has no reset; only pointers and count need a defined value
	always @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	// Pointers and occupancy
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (i_clk_en) begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				count <= count + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count <= count - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

/* File: inc/dvo_port_defs.vh */
// Constants for the digital video output port
`ifndef DVO_PORT_DEFS_VH
`define DVO_PORT_DEFS_VH

// Field/stall input modes
`define FS_MODE_OFF 2'h0
`define FS_MODE_FIELD 2'h1
`define FS_MODE_STALL 2'h2

// Shared pixel clock pin roles
`define PIXCLK_ROLE_REF 2'h0
`define PIXCLK_ROLE_IRQ_B 2'h1
`define PIXCLK_ROLE_IRQ_C 2'h2

// Shared interrupt routing
`define IRQ_ROUTE_B 1'h0
`define IRQ_ROUTE_C 1'h1

// Pixel and bus widths
`define PIX_WIDTH 24
`define HALF_WIDTH 12
`define TMG_WIDTH 12
`define FIFO_DEPTH 16
`define FIFO_AW 4

// Forwarded clock: system clock divided by two
`define SYS_CLK_MHZ 200
`define FWD_CLK_MAX_MHZ 165
`define FWD_CLK_DIV 2

// Card identification register offset
`define CARD_IDENT_REG_OFFSET 32'h00071408

// Pin synchroniser layout and reset value
`define SYNC_W 17
`define SYNC_RST 17'h0017f // Idle levels, so no false irq after reset
`define SYNC_TW_LSB 0
`define SYNC_IRQ_N 6
`define SYNC_PIXCLK 7
`define SYNC_DETECT 8
`define SYNC_STRAP_LSB 9

// Strap capture delay in enabled cycles after reset release
`define STRAP_CAPTURE_CNT 2'h3

`endif

/* File: testbench/digital_video_out_port_tb.sv */
// Self-checking testbench for the digital video output port
`timescale 1ns/1ps
`default_nettype none
module digital_video_out_port_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic i_clk_sys, i_reset_n, i_clk_en, i_pix_valid, o_pix_ready;
	logic i_hsync_pol, i_vsync_pol, i_blank_border_mode, i_irq_route;
	logic i_port_b_field_stall_in, i_port_c_field_stall_in, i_fs_b_pol;
	logic i_fs_c_pol, i_overlay_interleaved, o_port_c_fwd_clock;
	logic o_port_c_fwd_clock_n, o_port_c_hsync_out, o_port_c_vsync_out;
	logic o_port_c_blank_n, o_port_b_field, o_port_b_field_sync;
	logic o_port_b_stall, o_port_c_field, o_port_c_field_sync;
	logic o_port_c_stalled, i_shared_pixclk_or_irq_in, i_shared_video_irq_n;
	logic o_dot_clock_pll_ref_sel, o_port_b_irq, o_port_c_irq, i_card_detect;
	logic o_dvo_mode, o_ident_valid, i_mux_ctrl_bus_scl, i_mux_ctrl_bus_sda;
	logic i_primary_ddc_scl, i_primary_ddc_sda, i_secondary_ddc_scl;
	logic i_secondary_ddc_sda, o_mux_ctrl_bus_scl, o_mux_ctrl_bus_sda;
	logic o_primary_ddc_scl, o_primary_ddc_sda, o_secondary_ddc_scl;
	logic o_secondary_ddc_sda, o_mux_ctrl_bus_scl_oe_n, o_mux_ctrl_bus_sda_oe_n;
	logic o_primary_ddc_scl_oe_n, o_primary_ddc_sda_oe_n;
	logic o_secondary_ddc_scl_oe_n, o_secondary_ddc_sda_oe_n;
	logic [1:0] i_fs_b_mode, i_fs_c_mode, i_pixclk_mode;
	logic [5:0] i_twowire_drive_low, o_twowire_level, ext_low_n;
	logic [7:0] i_card_ident_strap, o_card_ident_reg;
	logic [11:0] i_h_active, i_h_border, i_h_sync_start, i_h_sync_width;
	logic [11:0] i_h_total, i_v_active, i_v_border, i_v_sync_start;
	logic [11:0] i_v_sync_width, i_v_total, o_port_c_pixel_bus;
	logic [23:0] i_pix_data;
	logic [23:0] sent[$];
	logic f, sb, sc, sst, sf;
	int fails = 0;
	int n_tests = 0;
	int k, n, nb, nh, nv;
	// Wired-low pins with pull-ups; the far side may pull low too
	wire [5:0] oe_n = {o_secondary_ddc_sda_oe_n, o_secondary_ddc_scl_oe_n,
		o_primary_ddc_sda_oe_n, o_primary_ddc_scl_oe_n,
		o_mux_ctrl_bus_sda_oe_n, o_mux_ctrl_bus_scl_oe_n};
	wire [5:0] drv = {o_secondary_ddc_sda, o_secondary_ddc_scl,
		o_primary_ddc_sda, o_primary_ddc_scl, o_mux_ctrl_bus_sda,
		o_mux_ctrl_bus_scl};
	assign {i_secondary_ddc_sda, i_secondary_ddc_scl, i_primary_ddc_sda,
		i_primary_ddc_scl, i_mux_ctrl_bus_sda,
		i_mux_ctrl_bus_scl} = (oe_n | drv) & ext_low_n;
	digital_video_out_port digital_video_out_port_inst (.*);
	video_sink video_sink_inst (
		.i_fwd(o_port_c_fwd_clock),
		.i_bus(o_port_c_pixel_bus),
		.i_blank_n(o_port_c_blank_n),
		.o_pixclk(i_shared_pixclk_or_irq_in),
		.o_irq_n(i_shared_video_irq_n),
		.o_fs(i_port_c_field_stall_in),
		.o_detect(i_card_detect),
		.o_ident(i_card_ident_strap)
	);
	// ****************************************
	// Tasks
	// ****************************************
	always #2.5 i_clk_sys = ~i_clk_sys;
	// Sticky flags so short pulses are not missed
	always @(posedge i_clk_sys) begin
		if (o_port_b_irq) sb <= 1'b1;
		if (o_port_c_irq) sc <= 1'b1;
		if (o_port_b_stall) sst <= 1'b1;
		if (o_port_c_field_sync || o_port_b_field_sync) sf <= 1'b1;
	end
	task cyc(input int c);
		repeat (c) @(negedge i_clk_sys);
	endtask
	task chk(input logic [23:0] seen, input logic [23:0] want);
		n_tests++;
		if (seen !== want) begin
			fails++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task stall_len(output int c);
		c = 0;
		repeat (12) if (!o_port_c_stalled) cyc(1);
		while (o_port_c_stalled && c < 200) begin
			c++;
			cyc(1);
		end
	endtask
	task end_sim;
		if (fails == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#100000;
		fails++;
		end_sim;
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		i_clk_sys = 1'b0;
		i_reset_n = 1'b0;
		i_clk_en = 1'b1;
		i_pix_data = 24'h0;
		{i_pix_valid, i_hsync_pol, i_vsync_pol, i_blank_border_mode,
			i_irq_route, i_port_b_field_stall_in, i_fs_b_pol, i_fs_c_pol,
			i_overlay_interleaved} = '0;
		{i_fs_b_mode, i_fs_c_mode, i_pixclk_mode} = '0;
		i_twowire_drive_low = 6'h3f;
		ext_low_n = 6'h3f;
		{i_h_active, i_h_border, i_h_sync_start, i_h_sync_width,
			i_h_total} = {12'h4, 12'h2, 12'h7, 12'h2, 12'hc};
		{i_v_active, i_v_border, i_v_sync_start, i_v_sync_width,
			i_v_total} = {12'h3, 12'h1, 12'h4, 12'h1, 12'h6};
		cyc(4);
		chk(oe_n, 6'h3f);
		i_reset_n = 1'b1;
		cyc(10);
		chk({o_dvo_mode, o_ident_valid, o_card_ident_reg}, {2'b11, 8'h5a});
		// One whole raster of 72 pixel periods per setting
		for (k = 0; k < 2; k++) begin
			{i_blank_border_mode, i_hsync_pol, i_vsync_pol} = k ? 3'b110 : 3'b001;
			cyc(4);
			nb = 0;
			nh = 0;
			nv = 0;
			repeat (144) begin
				cyc(1);
				nb += (o_port_c_fwd_clock && o_port_c_blank_n);
				nh += (o_port_c_fwd_clock && o_port_c_hsync_out);
				nv += (o_port_c_fwd_clock && o_port_c_vsync_out);
			end
			chk(nb, k ? 24 : 12);
			chk(nh, k ? 60 : 12);
			chk(nv, k ? 12 : 60);
		end
		for (k = 0; k < 6; k++) begin
			i_twowire_drive_low = 6'h01 << k;
			cyc(3);
			chk({oe_n, o_twowire_level}, {~(6'h01 << k), ~(6'h01 << k)});
		end
		i_twowire_drive_low = 6'h00;
		ext_low_n = 6'h2a;
		cyc(3);
		chk({oe_n, o_twowire_level}, {6'h3f, 6'h2a});
		for (k = 0; k < 2; k++) begin
			i_irq_route = k[0];
			video_sink_inst.o_irq_n = 1'b0;
			cyc(6);
			chk({o_port_b_irq, o_port_c_irq}, k ? 2'b01 : 2'b10);
			video_sink_inst.o_irq_n = 1'b1;
			cyc(6);
			chk({o_port_b_irq, o_port_c_irq}, 2'b00);
		end
		i_irq_route = 1'b0;
		for (k = 0; k < 3; k++) begin
			i_pixclk_mode = 2'(k);
			cyc(4);
			{sb, sc} = 2'b00;
			cyc(60);
			chk({o_dot_clock_pll_ref_sel, sb, sc}, {k == 0, k == 1, k == 2});
		end
		i_pixclk_mode = 2'h0;
		i_fs_c_mode = 2'h1;
		for (k = 0; k < 2; k++) begin
			i_overlay_interleaved = (k == 0);
			video_sink_inst.o_fs = 1'b0;
			cyc(10);
			sf = 1'b0;
			video_sink_inst.o_fs = 1'b1;
			cyc(10);
			chk({o_port_c_field, sf}, {2{k == 0}});
		end
		i_overlay_interleaved = 1'b1;
		i_fs_c_pol = 1'b1;
		cyc(10);
		chk(o_port_c_field, 1'b0);
		i_fs_b_mode = 2'h1;
		sf = 1'b0;
		i_port_b_field_stall_in = 1'b1;
		cyc(10);
		chk({o_port_b_field, sf}, 2'b11);
		i_port_b_field_stall_in = 1'b0;
		cyc(4);
		i_fs_b_mode = 2'h2;
		sst = 1'b0;
		i_port_b_field_stall_in = 1'b1;
		cyc(10);
		chk(sst, 1'b1);
		i_fs_b_mode = 2'h0;
		i_port_b_field_stall_in = 1'b0;
		cyc(10);
		sst = 1'b0;
		i_port_b_field_stall_in = 1'b1;
		cyc(10);
		chk(sst, 1'b0);
		i_clk_en = 1'b0;
		cyc(1);
		f = o_port_c_fwd_clock;
		cyc(5);
		chk({o_port_c_fwd_clock, o_pix_ready}, {f, 1'b0});
		i_clk_en = 1'b1;
		i_fs_c_mode = 2'h2;
		i_fs_c_pol = 1'b0;
		video_sink_inst.o_fs = 1'b0;
		cyc(8);
		// Fill the buffer until it refuses
		i_pix_valid = 1'b1;
		for (k = 0; k < 64 && o_pix_ready; k++) begin
			i_pix_data = {4'ha, 8'(k), 4'h5, 8'(k)};
			sent.push_back(i_pix_data);
			cyc(1);
		end
		i_pix_valid = 1'b0;
		chk(o_pix_ready, 1'b0);
		// Far side stalls the line while the buffer drains
		video_sink_inst.o_fs = 1'b1;
		stall_len(n);
		chk(n, 24);
		i_fs_c_pol = 1'b1;
		cyc(4);
		video_sink_inst.o_fs = 1'b0;
		stall_len(n);
		chk(n, 24);
		i_fs_c_mode = 2'h0;
		video_sink_inst.o_fs = 1'b1;
		cyc(4);
		video_sink_inst.o_fs = 1'b0;
		stall_len(n);
		chk(n, 0);
		repeat (3000) if (video_sink_inst.got.size() < sent.size()) cyc(1);
		chk(video_sink_inst.got.size(), sent.size());
		foreach (sent[i]) chk(video_sink_inst.got[i], sent[i]);
		// Second reset with no card fitted
		video_sink_inst.o_detect = 1'b1;
		i_reset_n = 1'b0;
		cyc(4);
		i_reset_n = 1'b1;
		cyc(10);
		chk({o_dvo_mode, o_ident_valid, o_card_ident_reg}, {2'b01, 8'h00});
		end_sim;
	end
endmodule
`default_nettype wire

/* File: testbench/dvo_port_sva.sv */
// Assertion checker for the digital video output port
`timescale 1ns/1ps
`default_nettype none
module dvo_port_sva (
	// Clock and control
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// Watched inputs
	input wire logic [1:0] i_pixclk_mode,
	input wire logic i_shared_video_irq_n,
	input wire logic i_irq_route,
	input wire logic [5:0] i_twowire_drive_low,
	input wire logic [7:0] i_card_ident_strap,
	input wire logic i_card_detect,
	// Watched outputs
	input wire logic o_port_c_fwd_clock,
	input wire logic o_port_c_fwd_clock_n,
	input wire logic o_port_c_hsync_out,
	input wire logic o_port_c_blank_n,
	input wire logic o_port_c_stalled,
	input wire logic o_port_c_irq,
	input wire logic o_dot_clock_pll_ref_sel,
	input wire logic o_dvo_mode,
	input wire logic [7:0] o_card_ident_reg,
	input wire logic o_ident_valid,
	input wire logic o_mux_ctrl_bus_scl_oe_n,
	input wire logic o_mux_ctrl_bus_sda_oe_n,
	input wire logic o_primary_ddc_scl_oe_n,
	input wire logic o_primary_ddc_sda_oe_n,
	input wire logic o_secondary_ddc_scl_oe_n,
	input wire logic o_secondary_ddc_sda_oe_n
);
	// ****************************************
	// Properties
	// ****************************************
	// Enables gathered in drive-request bit order
	wire [5:0] oe_n = {o_secondary_ddc_sda_oe_n, o_secondary_ddc_scl_oe_n,
		o_primary_ddc_sda_oe_n, o_primary_ddc_scl_oe_n,
		o_mux_ctrl_bus_sda_oe_n, o_mux_ctrl_bus_scl_oe_n};
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);
	property p_fwd;
		i_clk_en |=> $changed(o_port_c_fwd_clock)
			&& o_port_c_fwd_clock_n != o_port_c_fwd_clock;
	endproperty
	a_fwd: assert property (p_fwd) else $error("fwd clock");
	property p_freeze;
		!i_clk_en |=> $stable(o_port_c_fwd_clock);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze");
	property p_tw_reset;
		$rose(i_reset_n) |-> oe_n == 6'h3f;
	endproperty
	a_tw_reset: assert property (p_tw_reset) else $error("float");
	property p_tw_drive;
		i_clk_en |=> oe_n == ~$past(i_twowire_drive_low);
	endproperty
	a_tw_drive: assert property (p_tw_drive) else $error("drive");
	property p_pll;
		i_clk_en |=> o_dot_clock_pll_ref_sel == ($past(i_pixclk_mode) == 2'h0);
	endproperty
	a_pll: assert property (p_pll) else $error("pll sel");
	// Three synchroniser edges before the level shows
	property p_irq_c;
		(!i_shared_video_irq_n && i_irq_route && i_clk_en) [*3] |=> o_port_c_irq;
	endproperty
	a_irq_c: assert property (p_irq_c) else $error("irq");
	property p_ident;
		$rose(o_ident_valid) |-> o_dvo_mode == !i_card_detect
			&& o_card_ident_reg == (i_card_detect ? 8'h00 : i_card_ident_strap);
	endproperty
	a_ident: assert property (p_ident) else $error("ident");
	property p_stall_blank;
		// Blank only updates at period starts, so look just after one
		o_port_c_stalled [*2] ##0 o_port_c_fwd_clock
			|-> !o_port_c_blank_n;
	endproperty
	a_stall_blank: assert property (p_stall_blank) else $error("stall");
	property p_hsync;
		$changed(o_port_c_hsync_out) |-> o_port_c_fwd_clock;
	endproperty
	a_hsync: assert property (p_hsync) else $error("hsync");
	c_stall: cover property ($rose(o_port_c_stalled));
	c_irq: cover property ($rose(o_port_c_irq));
	c_ident: cover property ($rose(o_ident_valid));
endmodule
bind digital_video_out_port dvo_port_sva dvo_port_sva_inst (.*);
`default_nettype wire

/* File: testbench/video_sink.sv */
// Behavioural far-side receiver model for the video port
`timescale 1ns/1ps
`default_nettype none
module video_sink (
	// Video pins from the port
	input wire logic i_fwd,
	input wire logic [11:0] i_bus,
	input wire logic i_blank_n,
	// Side-band pins toward the port
	output logic o_pixclk,
	output logic o_irq_n,
	output logic o_fs,
	output logic o_detect,
	output logic [7:0] o_ident
);
	// ****************************************
	// Sink
	// ****************************************
	logic [11:0] low;
	logic [23:0] got[$];
	// Reference clock runs free, unrelated to the system clock
	initial o_pixclk = 1'b0;
	always #62.5 o_pixclk = ~o_pixclk;
	// Idle side-band; a present card pulls detect low
	initial begin
		o_irq_n = 1'b1;
		o_fs = 1'b0;
		o_detect = 1'b0;
		o_ident = 8'h5a;
	end
	// Low half rides the true-phase rise
	always @(posedge i_fwd) #1 low = i_bus;
	// Empty buffer shows zero, so zero words are not kept
	always @(negedge i_fwd) #1 if (i_blank_n && {i_bus, low} != 24'h0)
		got.push_back({i_bus, low});
endmodule
`default_nettype wire
